// File: logic/reset_hold_ack_interlock.sv
// Interlock sequencing processor resets against DMA bus ownership
`timescale 1ns/1ps
`include "reset_interlock_map.svh"

module reset_hold_ack_interlock
    import reset_interlock_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Processor side pins
    input wire logic cpu_hold_granted,
    output logic processor_reset_out,
    // Reset requests
    input wire logic reset_request_in,
    input wire logic fast_reset_strobe,
    // DMA controller side
    output logic dma_grant_out
);

    localparam logic [`PULSE_COUNT_W-1:0] PULSE_LAST =
        `PULSE_COUNT_W'(`CPU_RESET_PULSE_CYCLES - 1);

    logic hold_sync;
    logic req_sync;
    logic req_sync_d;
    logic next_req_sync_d;
    logic reset_pending;
    logic next_reset_pending;
    logic grant_deferred;
    logic next_grant_deferred;
    logic [`PULSE_COUNT_W-1:0] pulse_count;
    logic [`PULSE_COUNT_W-1:0] next_pulse_count;
    interlock_state_t state;
    interlock_state_t next_state;
    logic next_processor_reset_out;
    logic next_dma_grant_out;
    logic reset_request;

    // Pins arrive from outside the clock domain
    level_sync hold_sync_inst
    (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .async_in(cpu_hold_granted),
        .sync_out(hold_sync)
    );

    level_sync req_sync_inst
    (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .async_in(reset_request_in),
        .sync_out(req_sync)
    );

    // Hardware request taken on its rising edge; port strobe is same-clock logic
    assign reset_request = (req_sync && !req_sync_d) || fast_reset_strobe;

    always_comb
    begin
        next_state = state;
        next_req_sync_d = req_sync;
        next_reset_pending = reset_pending || reset_request;
        next_grant_deferred = grant_deferred;
        next_pulse_count = pulse_count;
        next_processor_reset_out = 1'b0;
        next_dma_grant_out = 1'b0;
        unique case (state)
            st_idle:
            begin
                if (reset_pending || reset_request)
                begin
                    // Reset wins a tie with acknowledge; grant stays low
                    next_state = st_reset_pulse;
                    next_grant_deferred = hold_sync;
                    next_reset_pending = 1'b0;
                    next_pulse_count = '0;
                    next_processor_reset_out = 1'b1;
                end
                else if (hold_sync)
                begin
                    next_state = st_dma_owned;
                    next_dma_grant_out = 1'b1;
                end
            end
            st_dma_owned:
            begin
                if (hold_sync)
                begin
                    // Request is only latched; reset waits for the cycle to end
                    next_dma_grant_out = 1'b1;
                end
                else if (reset_pending || reset_request)
                begin
                    next_state = st_reset_pulse;
                    next_grant_deferred = 1'b0;
                    next_reset_pending = 1'b0;
                    next_pulse_count = '0;
                    next_processor_reset_out = 1'b1;
                end
                else
                begin
                    next_state = st_idle;
                end
            end
            st_reset_pulse:
            begin
                // Acknowledge seen during the pulse is still trusted, though the processor
                // drops it under reset: it sets the pending grant, given when the pulse ends
                next_reset_pending = 1'b0;
                if (hold_sync)
                begin
                    next_grant_deferred = 1'b1;
                end
                if (pulse_count == PULSE_LAST)
                begin
                    if (grant_deferred || hold_sync)
                    begin
                        next_state = st_grant_deferred;
                        next_dma_grant_out = 1'b1;
                    end
                    else
                    begin
                        next_state = st_idle;
                    end
                end
                else
                begin
                    next_pulse_count = pulse_count + `PULSE_COUNT_W'(1);
                    next_processor_reset_out = 1'b1;
                end
            end
            st_grant_deferred:
            begin
                // Grant held until the processor acknowledges again
                next_grant_deferred = 1'b0;
                next_dma_grant_out = 1'b1;
                if (hold_sync)
                begin
                    next_state = st_dma_owned;
                end
            end
        endcase
        if (!ce)
        begin
            next_state = state;
            next_req_sync_d = req_sync_d;
            next_reset_pending = reset_pending;
            next_grant_deferred = grant_deferred;
            next_pulse_count = pulse_count;
            next_processor_reset_out = processor_reset_out;
            next_dma_grant_out = dma_grant_out;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= st_idle;
            req_sync_d <= 1'b0;
            reset_pending <= 1'b0;
            grant_deferred <= 1'b0;
            pulse_count <= '0;
            processor_reset_out <= 1'b0;
            dma_grant_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            req_sync_d <= next_req_sync_d;
            reset_pending <= next_reset_pending;
            grant_deferred <= next_grant_deferred;
            pulse_count <= next_pulse_count;
            processor_reset_out <= next_processor_reset_out;
            dma_grant_out <= next_dma_grant_out;
        end
    end

endmodule

// File: logic/reset_interlock_map.svh
// Offsets-free constant map: timing counts for the reset/hold interlock
`ifndef RESET_INTERLOCK_MAP_SVH
`define RESET_INTERLOCK_MAP_SVH

// Clock period in picoseconds (25 MHz)
`define CLK_PERIOD_PS 40000
// Processor reset pulse width in nanoseconds
`define CPU_RESET_PULSE_NS 640
// Pulse width in cycles, rounded up to whole cycles
`define CPU_RESET_PULSE_CYCLES ((`CPU_RESET_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Width of the pulse counter
`define PULSE_COUNT_W 8
// Reset value of the synchroniser stages
`define SYNC_RESET_VALUE 1'b0

`endif

// File: logic/reset_interlock_pkg.sv
// Types shared by the reset/hold interlock
package reset_interlock_pkg;

    typedef enum logic [2:0]
    {
        st_idle,
        st_dma_owned,
        st_reset_pulse,
        st_grant_deferred
    } interlock_state_t;

endpackage

// File: logic/level_sync.sv
// Two flip-flop synchroniser for a level from another domain
`timescale 1ns/1ps
`include "reset_interlock_map.svh"

module level_sync
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);

    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    // First stage feeds only the second
    always_comb
    begin
        next_stage1 = ce ? async_in : stage1;
        next_sync_out = ce ? stage1 : sync_out;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1 <= `SYNC_RESET_VALUE;
            sync_out <= `SYNC_RESET_VALUE;
        end
        else
        begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule

// File: dv/cpu_hold_model.sv
// Processor hold handshake model facing the interlock
`timescale 1ns/1ps
module cpu_hold_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Hold request and processor reset
    input wire logic hold_want,
    input wire logic processor_reset_out,
    // Hold acknowledge pin
    output logic cpu_hold_granted
);
    // Acknowledge is withdrawn whenever the processor sits in reset
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            cpu_hold_granted <= 1'h0;
        else
            cpu_hold_granted <= hold_want && !processor_reset_out;
endmodule

// File: dv/reset_hold_ack_interlock_assertions.sv
// Port checks of the reset/hold interlock
`timescale 1ns/1ps
module reset_hold_ack_interlock_assertions
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Pins
    input wire logic cpu_hold_granted,
    input wire logic processor_reset_out,
    input wire logic reset_request_in,
    input wire logic fast_reset_strobe,
    input wire logic dma_grant_out
);
    default clocking cb @(posedge clk); endclocking
    // A frozen enable stretches every timed behaviour, so attempts are dropped
    default disable iff (!resetn || !ce);
    // Ack quiet long enough that no ownership can be under way
    sequence s_quiet_strobe;
        !cpu_hold_granted[*4] ##0 ce && fast_reset_strobe && !dma_grant_out && !processor_reset_out;
    endsequence
    sequence s_owned_strobe;
        cpu_hold_granted[*5] ##0 dma_grant_out && fast_reset_strobe;
    endsequence
    AST_NEVER_BOTH: assert property (!(dma_grant_out && processor_reset_out))
        else $error("grant high during processor reset");
    AST_RESET_FIRST: assert property (s_quiet_strobe |-> ##[1:2] processor_reset_out)
        else $error("strobe did not start reset");
    AST_PULSE: assert property ($rose(processor_reset_out) |->
        processor_reset_out[*8] ##1 processor_reset_out[*8] ##1 !processor_reset_out)
        else $error("reset pulse width wrong");
    AST_DEFERRED: assert property ($fell(processor_reset_out) && $past(cpu_hold_granted, 16)
        |-> dma_grant_out)
        else $error("deferred grant missing");
    AST_HOLD_OFF: assert property (s_owned_strobe |=> (!processor_reset_out && dma_grant_out)[*2])
        else $error("reset cut into transfer");
    // Pin to registered grant is three sampling edges through the synchroniser
    AST_GRANT_FALL: assert property ($fell(dma_grant_out) |-> !$past(cpu_hold_granted, 3))
        else $error("grant fell with ack high");
endmodule
bind reset_hold_ack_interlock reset_hold_ack_interlock_assertions chk
(
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .cpu_hold_granted(cpu_hold_granted),
    .processor_reset_out(processor_reset_out),
    .reset_request_in(reset_request_in),
    .fast_reset_strobe(fast_reset_strobe),
    .dma_grant_out(dma_grant_out)
);

// File: dv/reset_hold_ack_interlock_test.sv
// Self-checking bench for the reset/hold interlock
`timescale 1ns/1ps
`include "reset_interlock_map.svh"
module reset_hold_ack_interlock_test;
    logic clk = 1'h0, resetn = 1'h0, req = 1'h0, strobe = 1'h0, want = 1'h0, ce = 1'h1;
    logic ack, rst_out, grant;
    int n_mismatch = 0, tests_run = 0, n, i;
    // Rows: hardware request, hold wanted, grant expected after pulse
    logic [2:0] rows [4] = '{3'h0, 3'h4, 3'h3, 3'h7};
    reset_hold_ack_interlock uut (.clk(clk), .resetn(resetn), .ce(ce),
        .cpu_hold_granted(ack), .processor_reset_out(rst_out), .reset_request_in(req),
        .fast_reset_strobe(strobe), .dma_grant_out(grant));
    cpu_hold_model cpu (.clk(clk), .resetn(resetn), .hold_want(want),
        .processor_reset_out(rst_out), .cpu_hold_granted(ack));
    initial forever #20 clk = ~clk;
    task stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    // Bounded wait for the processor reset to reach a level
    task wait_reset(input logic lvl);
        n = 0;
        do
        begin
            tick;
            n++;
        end
        while (rst_out !== lvl && n < 40);
    endtask
    initial
    begin
        #20000;
        n_mismatch++;
        stop_test;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        tick;
        check("reset_out", 8'h0, rst_out);
        check("grant", 8'h0, grant);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            req <= rows[i][2];
            want <= rows[i][1];
            strobe <= !rows[i][2];
            @(posedge clk);
            strobe <= 1'h0;
            wait_reset(1'h1);
            wait_reset(1'h0);
            // Strobe rows: pulse rose at the edge before the wait began
            check("pulse_len", 8'(`CPU_RESET_PULSE_CYCLES - (rows[i][2] ? 0 : 1)), n[7:0]);
            check("grant_after", {7'h0, rows[i][0]}, grant);
            @(posedge clk);
            want <= 1'h0;
            req <= 1'h0;
            repeat (8) tick;
            check("grant_idle", 8'h0, grant);
            $display("Row %0d done", i);
        end
        @(posedge clk);
        want <= 1'h1;
        repeat (8) tick;
        check("grant_owned", 8'h1, grant);
        @(posedge clk);
        strobe <= 1'h1;
        @(posedge clk);
        strobe <= 1'h0;
        repeat (5) tick;
        check("reset_held", 8'h0, rst_out);
        @(posedge clk);
        want <= 1'h0;
        wait_reset(1'h1);
        check("grant_at_reset", 8'h0, grant);
        wait_reset(1'h0);
        check("grant_end", 8'h0, grant);
        $display("Deferral test done");
        @(posedge clk);
        strobe <= 1'h1;
        @(posedge clk);
        strobe <= 1'h0;
        repeat (4) @(posedge clk);
        ce <= 1'h0;
        repeat (20) tick;
        check("reset_frozen", 8'h1, rst_out);
        @(posedge clk);
        ce <= 1'h1;
        wait_reset(1'h0);
        check("reset_after_freeze", 8'h0, rst_out);
        check("grant_after_freeze", 8'h0, grant);
        $display("Enable freeze test done");
        stop_test;
    end
endmodule
